// ### tpo_map.svh
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH

`define TPO_ADDR_PERIOD_LOW 8'hB5
`define TPO_ADDR_DUTY_C 8'hBB
`define TPO_ADDR_HIGH 8'hBC
`define TPO_ADDR_FORCE 8'hBD
`define TPO_ADDR_CTRL3 8'hBE
`define TPO_ADDR_DLY_A 8'hBF
`define TPO_ADDR_DLY_B 8'hC2
`define TPO_ADDR_DLY_C 8'hC3
`define TPO_ADDR_FLAGS 8'hC4
`define TPO_ADDR_MASKS 8'hC5

`define TPO_RST_DUTY 8'h7F
`define TPO_RST_PERIOD 8'hFF
`define TPO_RST_ZERO 8'h00
`define TPO_RST_LVL 5'h1F

`define TPO_HI_A 7:6
`define TPO_HI_B 5:4
`define TPO_HI_C 3:2
`define TPO_HI_P 1:0

`define TPO_FORCE_A 7
`define TPO_FORCE_SIX 6
`define TPO_OUT_EN 5:0

`define TPO_PORT_EN 7
`define TPO_POL_A 6
`define TPO_POL_B 5
`define TPO_POL_C 4
`define TPO_OCON 3
`define TPO_HIGH_FREQ_CLOCK_ENABLE 2
`define TPO_PLL_ON 0
`define TPO_CTRL3_WMASK 8'hFD

`define TPO_DLY_TRUE 7:4
`define TPO_DLY_COMP 3:0

`define TPO_F_OVF 7
`define TPO_F_BTM 6
`define TPO_F_MA 5
`define TPO_F_MB 4
`define TPO_F_MC 3
`define TPO_F_CAP 2
`define TPO_FLAG_MASK 8'hFC

`define TPO_NOP_DIV1 3'h0
`define TPO_NOP_DIV2 3'h1
`define TPO_NOP_DIV4 3'h3
`define TPO_NOP_DIV8 3'h7

`define TPO_CNT_ZERO 10'h000
`define TPO_ALL_ON 6'h3F
`define TPO_ALL_OFF 6'h00
`define TPO_CLK_PERIOD_NS 10
`define TPO_PLL_WAIT_NS 1000000

`endif

// ### tpo_pkg.sv
`default_nettype none
package tpo_pkg;
    typedef logic [7:0] tpo_byte_t;
    typedef logic [9:0] tpo_val_t;
    typedef logic [5:0] tpo_six_t;
    typedef logic [2:0] tpo_chan_t;
endpackage
`default_nettype wire

// ### tpo_rise_dly.sv
`default_nettype none
module tpo_rise_dly
    import tpo_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Waveform in and delay setting
    input wire logic in_i,
    input wire logic tick_i,
    input wire logic [3:0] delay_i,
    // Delayed waveform
    output logic out_o
);
    logic [3:0] cnt_q;
    logic out_q;

    // Falling edges pass at once; only the rising edge waits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (!in_i) begin
            out_q <= 1'b0;
            cnt_q <= 4'h0;
        end else if (!out_q) begin
            if (cnt_q >= delay_i) begin
                out_q <= 1'b1;
            end else if (tick_i) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    assign out_o = out_q;
endmodule
`default_nettype wire

// ### tpo_stage.sv
`include "tpo_map.svh"
`default_nettype none
module tpo_stage
    import tpo_pkg::*;
#(
    parameter logic [16:0] PLL_WAIT_CYC =
        17'(`TPO_PLL_WAIT_NS / `TPO_CLK_PERIOD_NS)
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // Counter core
    input wire logic pwm_enable_bit_i,
    input wire logic btb_mode_i,
    input wire logic [1:0] nops_sel_i,
    input wire logic [9:0] counter_i,
    input wire logic [7:0] duty_a_low_i,
    input wire logic [7:0] duty_b_low_i,
    input wire logic timer_match_i,
    input wire logic capture_i,
    // Values to the counter core
    output logic [9:0] period_o,
    output logic [9:0] duty_c_o,
    // PWM pins
    output logic [5:0] pwm_o,
    output logic [5:0] pwm_oe_o,
    // Clocking and interrupt
    output logic pll_power_on_o,
    output logic pll_stable_o,
    output logic high_freq_clock_enable_o,
    output logic irq_o
);
    function automatic logic eq10(input tpo_val_t a, input tpo_val_t b);
        eq10 = (a == b);
    endfunction

    function automatic logic [2:0] nop_mask(input logic [1:0] sel);
        unique case (sel)
            2'h0: nop_mask = `TPO_NOP_DIV1;
            2'h1: nop_mask = `TPO_NOP_DIV2;
            2'h2: nop_mask = `TPO_NOP_DIV4;
            2'h3: nop_mask = `TPO_NOP_DIV8;
        endcase
    endfunction

    tpo_byte_t period_low_q, duty_c_q, high_q, force_q, ctrl3_q;
    tpo_byte_t dly_a_q, dly_b_q, dly_c_q, flags_q, masks_q, rdata_q;
    tpo_byte_t flag_set, flag_clr;
    tpo_val_t period_v, duty_a_v, duty_b_v, duty_c_v;
    logic [4:0] lvl, lvl_q, ev;
    tpo_chan_t wave_q, pol, src;
    tpo_six_t raw, dly_out, en6, pwm_q, oe_q;
    logic [23:0] dly_vec;
    logic [2:0] pre_q;
    logic tick_q, run, irq_q, pll_stable_q;
    logic [16:0] pll_cnt_q;

    function automatic logic hit(input logic [7:0] a);
        hit = reg_we_i && (reg_addr_i == a);
    endfunction

    // Register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_low_q <= `TPO_RST_PERIOD;
            duty_c_q <= `TPO_RST_DUTY;
            high_q <= `TPO_RST_ZERO;
            force_q <= `TPO_RST_ZERO;
            ctrl3_q <= `TPO_RST_ZERO;
            dly_a_q <= `TPO_RST_ZERO;
            dly_b_q <= `TPO_RST_ZERO;
            dly_c_q <= `TPO_RST_ZERO;
            masks_q <= `TPO_RST_ZERO;
        end else begin
            if (hit(`TPO_ADDR_PERIOD_LOW)) begin
                period_low_q <= reg_wdata_i;
            end
            // Software is expected to write this only with PWM enabled
            if (hit(`TPO_ADDR_DUTY_C)) begin
                duty_c_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_HIGH)) begin
                high_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_FORCE)) begin
                force_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_CTRL3)) begin
                ctrl3_q <= reg_wdata_i & `TPO_CTRL3_WMASK;
            end
            if (hit(`TPO_ADDR_DLY_A)) begin
                dly_a_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_DLY_B)) begin
                dly_b_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_DLY_C)) begin
                dly_c_q <= reg_wdata_i;
            end
            if (hit(`TPO_ADDR_MASKS)) begin
                masks_q <= reg_wdata_i & `TPO_FLAG_MASK;
            end
        end
    end

    // Read data stands for as many cycles as the read strobe is held, then clears; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !reg_re_i) begin
            rdata_q <= `TPO_RST_ZERO;
        end else begin
            unique case (reg_addr_i)
                `TPO_ADDR_DUTY_C: rdata_q <= duty_c_q;
                `TPO_ADDR_HIGH: rdata_q <= high_q;
                `TPO_ADDR_FORCE: rdata_q <= force_q;
                `TPO_ADDR_CTRL3: rdata_q <= ctrl3_q;
                `TPO_ADDR_DLY_A: rdata_q <= dly_a_q;
                `TPO_ADDR_DLY_B: rdata_q <= dly_b_q;
                `TPO_ADDR_DLY_C: rdata_q <= dly_c_q;
                `TPO_ADDR_FLAGS: rdata_q <= flags_q;
                `TPO_ADDR_MASKS: rdata_q <= masks_q;
                default: rdata_q <= `TPO_RST_ZERO;
            endcase
        end
    end

    // Ten-bit values
    assign period_v = {high_q[`TPO_HI_P], period_low_q};
    assign duty_a_v = {high_q[`TPO_HI_A], duty_a_low_i};
    assign duty_b_v = {high_q[`TPO_HI_B], duty_b_low_i};
    assign duty_c_v = {high_q[`TPO_HI_C], duty_c_q};

    // Match levels; an event is the first cycle of a level
    assign lvl = {eq10(counter_i, period_v), eq10(counter_i, duty_a_v),
                  eq10(counter_i, duty_b_v), eq10(counter_i, duty_c_v),
                  eq10(counter_i, `TPO_CNT_ZERO)};
    assign ev = lvl & ~lvl_q;

    // Level history starts all high so reset release fires no event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_q <= `TPO_RST_LVL;
        end else begin
            lvl_q <= lvl;
        end
    end

    // Event flags; a set in the same cycle as its clear wins
    always_comb begin
        flag_set = `TPO_RST_ZERO;
        flag_set[`TPO_F_OVF] = pwm_enable_bit_i ? ev[4] : timer_match_i;
        flag_set[`TPO_F_BTM] = pwm_enable_bit_i & btb_mode_i & ev[0];
        flag_set[`TPO_F_MA] = pwm_enable_bit_i ? ev[3] : timer_match_i;
        flag_set[`TPO_F_MB] = pwm_enable_bit_i & ev[2];
        flag_set[`TPO_F_MC] = pwm_enable_bit_i & ev[1];
        flag_set[`TPO_F_CAP] = capture_i;
        flag_clr = hit(`TPO_ADDR_FLAGS) ? (reg_wdata_i & `TPO_FLAG_MASK)
                                        : `TPO_RST_ZERO;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= `TPO_RST_ZERO;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // Interrupt request lags its flag by one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & masks_q);
        end
    end

    // Channel waveforms before complement and delay
    assign pol = {ctrl3_q[`TPO_POL_A], ctrl3_q[`TPO_POL_B],
                  ctrl3_q[`TPO_POL_C]};
    assign run = pwm_enable_bit_i & ctrl3_q[`TPO_OCON];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_q <= 3'h7;
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (!pwm_enable_bit_i || ev[4] || (btb_mode_i && ev[0])) begin
                    wave_q[c] <= ~pol[c];
                end else if (ev[c + 1]) begin
                    wave_q[c] <= pol[c];
                end
            end
        end
    end

    // Force-drive-A copies channel A onto all three channels
    assign src = force_q[`TPO_FORCE_A] ? {3{wave_q[2]}} : wave_q;
    // Idle drives both halves low so no pair can overlap
    assign raw = run ? {src[2], ~src[2], src[1], ~src[1], src[0], ~src[0]}
                     : `TPO_ALL_OFF;

    // Non-overlap prescaler tick, a fraction of the PWM clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 3'h1;
            tick_q <= (pre_q & nop_mask(nops_sel_i)) == 3'h0;
        end
    end

    assign dly_vec = {dly_a_q, dly_b_q, dly_c_q};

    for (genvar i = 0; i < 6; i++) begin : g_dly
        tpo_rise_dly u_dly (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_i(raw[i]),
            .tick_i(tick_q),
            .delay_i(dly_vec[i * 4 +: 4]),
            .out_o(dly_out[i])
        );
    end

    // Output enables only count in force-six mode
    assign en6 = force_q[`TPO_FORCE_SIX] ? force_q[`TPO_OUT_EN]
                                         : `TPO_ALL_ON;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_q <= `TPO_ALL_OFF;
            oe_q <= `TPO_ALL_OFF;
        end else if (ctrl3_q[`TPO_PORT_EN]) begin
            pwm_q <= dly_out & en6;
            oe_q <= `TPO_ALL_ON;
        end else begin
            pwm_q <= `TPO_ALL_OFF;
            oe_q <= `TPO_ALL_OFF;
        end
    end

    // PLL settle timer; powering down restarts the wait
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl3_q[`TPO_PLL_ON]) begin
            pll_cnt_q <= 17'h00000;
            pll_stable_q <= 1'b0;
        end else if (pll_cnt_q == PLL_WAIT_CYC - 17'h00001) begin
            pll_stable_q <= 1'b1;
        end else begin
            pll_cnt_q <= pll_cnt_q + 17'h00001;
        end
    end

    // Software must only select this with a fast enough PLL
    assign high_freq_clock_enable_o = ctrl3_q[`TPO_HIGH_FREQ_CLOCK_ENABLE];
    assign pll_power_on_o = ctrl3_q[`TPO_PLL_ON];
    assign pll_stable_o = pll_stable_q;
    assign period_o = period_v;
    assign duty_c_o = duty_c_v;
    assign pwm_o = pwm_q;
    assign pwm_oe_o = oe_q;
    assign irq_o = irq_q;
    assign reg_rdata_o = rdata_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    duty_reset_val_a: assert property (
        $fell(rst_i) |-> duty_c_q == `TPO_RST_DUTY
                         && period_low_q == `TPO_RST_PERIOD)
        else $error("duty or period reset value wrong");
    high_bits_a: assert property (
        duty_c_o[9:8] == high_q[3:2] && period_o[9:8] == high_q[1:0])
        else $error("high bits misplaced");
    read_back_a: assert property (
        reg_re_i && reg_addr_i == `TPO_ADDR_HIGH && !reg_we_i
        |=> reg_rdata_o == high_q)
        else $error("high register read back wrong");
    force_six_off_a: assert property (
        ctrl3_q[`TPO_PORT_EN] && !force_q[`TPO_FORCE_SIX]
        |=> pwm_o == $past(dly_out))
        else $error("enables applied outside force-six");
    port_off_a: assert property (
        !ctrl3_q[`TPO_PORT_EN] |=> pwm_oe_o == 6'h00 && pwm_o == 6'h00)
        else $error("pins driven with port disabled");
    period_inactive_a: assert property (
        pwm_enable_bit_i && ev[4] |=> wave_q == ~$past(pol))
        else $error("period match did not restore inactive level");
    duty_switch_a: assert property (
        pwm_enable_bit_i && ev[2] && !ev[4] && !(btb_mode_i && ev[0])
        |=> wave_q[1] == $past(pol[1]))
        else $error("duty match did not switch channel");
    set_wins_a: assert property (
        flag_set[`TPO_F_CAP] |=> flags_q[`TPO_F_CAP])
        else $error("capture flag lost");
    w1c_clear_a: assert property (
        flag_clr[`TPO_F_OVF] && !flag_set[`TPO_F_OVF]
        |=> !flags_q[`TPO_F_OVF])
        else $error("overflow flag not cleared");
    bottom_flag_a: assert property (
        pwm_enable_bit_i && btb_mode_i && ev[0] |=> flags_q[`TPO_F_BTM])
        else $error("bottom flag not set");
    irq_gate_a: assert property (
        (masks_q & flags_q) == 8'h00 ##1 (masks_q & flags_q) == 8'h00
        |-> !irq_o)
        else $error("interrupt without enabled flag");
    fall_pass_a: assert property (
        !raw[5] |=> ##1 !pwm_o[5])
        else $error("falling edge delayed");

    cover_btb_c: cover property (btb_mode_i && flags_q[`TPO_F_BTM]);
    cover_force_c: cover property (force_q[`TPO_FORCE_A] && run ##1 ev[3]);
    cover_irq_c: cover property ($rose(irq_o));
    cover_pll_c: cover property ($rose(pll_stable_o));
endmodule
`default_nettype wire

// ### tpo_load.sv
`default_nettype none
module tpo_load
    import tpo_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Pins from the stage
    input wire logic [5:0] pwm_i,
    input wire logic [5:0] oe_i,
    // Level at the loads and shoot-through count
    output logic [5:0] pin_o,
    output logic [7:0] overlap_o
);
    // Loads sit on pull-downs, so a released pin reads low
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_o[i] = oe_i[i] ? pwm_i[i] : 1'b0;
        end
    end
    // True and complement high together would short a bridge leg
    initial overlap_o = 8'h00;
    always @(posedge clk_i) begin
        if ((pin_o[5] & pin_o[4]) | (pin_o[3] & pin_o[2])
            | (pin_o[1] & pin_o[0])) begin
            overlap_o <= overlap_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
`include "tpo_map.svh"
`default_nettype none
module testbench
    import tpo_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {tpo_val_t cnt; logic cap; tpo_byte_t flag;} tpo_row_t;
    localparam tpo_val_t IDLE = 10'h3F0;
    localparam tpo_byte_t ADDRS [10] = '{8'hBB, 8'hBC, 8'hBD, 8'hBE,
        8'hBF, 8'hC2, 8'hC3, 8'hC5, 8'hB5, 8'h10};
    localparam tpo_byte_t RSTV [10] = '{8'h7F, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam tpo_byte_t BACKV [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFD,
        8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'h00, 8'h00};
    tpo_row_t rows [6] = '{'{10'h0FF, 1'b0, 8'h80}, '{10'h000, 1'b0, 8'h40},
        '{10'h040, 1'b0, 8'h20}, '{10'h050, 1'b0, 8'h10},
        '{10'h07F, 1'b0, 8'h08}, '{IDLE, 1'b1, 8'h04}};
    logic clk_i, rst_i, reg_we_i, reg_re_i, pwm_enable_bit_i, btb_mode_i;
    logic [7:0] reg_addr_i, reg_wdata_i, duty_a_low_i, duty_b_low_i;
    logic [1:0] nops_sel_i;
    logic timer_match_i, capture_i;
    logic pll_power_on_o, pll_stable_o, high_freq_clock_enable_o, irq_o;
    tpo_val_t counter_i, period_o, duty_c_o;
    tpo_byte_t reg_rdata_o, rd;
    tpo_six_t pwm_o, pwm_oe_o, pin;
    logic [7:0] overlap;
    int fail_count, checked, cyc, n;

    tpo_stage #(.PLL_WAIT_CYC(17'd20)) i_tpo_stage (.clk_i(clk_i),
        .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .pwm_enable_bit_i(pwm_enable_bit_i), .btb_mode_i(btb_mode_i),
        .nops_sel_i(nops_sel_i), .counter_i(counter_i),
        .duty_a_low_i(duty_a_low_i), .duty_b_low_i(duty_b_low_i),
        .timer_match_i(timer_match_i), .capture_i(capture_i),
        .period_o(period_o), .duty_c_o(duty_c_o), .pwm_o(pwm_o),
        .pwm_oe_o(pwm_oe_o), .pll_power_on_o(pll_power_on_o),
        .pll_stable_o(pll_stable_o),
        .high_freq_clock_enable_o(high_freq_clock_enable_o), .irq_o(irq_o));
    tpo_load i_tpo_load (.clk_i(clk_i), .pwm_i(pwm_o), .oe_i(pwm_oe_o),
        .pin_o(pin), .overlap_o(overlap));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected run length
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic chk8(input string nm, input tpo_byte_t e, tpo_byte_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk10(input string nm, input tpo_val_t e, tpo_val_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk6(input string nm, input tpo_six_t e, tpo_six_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, logic g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr_reg(input tpo_byte_t a, input tpo_byte_t d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    task automatic rd_reg(input tpo_byte_t a, output tpo_byte_t d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // Counter shows v for one cycle; returns at the edge that sees it
    task automatic hit(input tpo_val_t v);
        @(posedge clk_i);
        counter_i <= v;
        @(posedge clk_i);
        counter_i <= IDLE;
    endtask
    task automatic rise(input tpo_val_t v, input int b, output int k);
        hit(v);
        k = 0;
        while (pin[b] !== 1'b1 && k < 40) begin
            @(posedge clk_i);
            #1 k++;
        end
    endtask

    initial begin
        rst_i = 1'b1;
        {reg_we_i, reg_re_i, timer_match_i, capture_i} = 4'h0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        {pwm_enable_bit_i, btb_mode_i} = 2'b11;
        nops_sel_i = 2'h0;
        counter_i = IDLE;
        duty_a_low_i = 8'h40;
        duty_b_low_i = 8'h50;
        fail_count = 0;
        checked = 0;
        cyc = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk_i);
            counter_i <= rows[i].cnt;
            capture_i <= rows[i].cap;
            @(posedge clk_i);
            counter_i <= IDLE;
            capture_i <= 1'b0;
            rd_reg(`TPO_ADDR_FLAGS, rd);
            chk8("flag set", rows[i].flag, rd);
            wr_reg(`TPO_ADDR_FLAGS, 8'h00);
            rd_reg(`TPO_ADDR_FLAGS, rd);
            chk8("flag kept", rows[i].flag, rd);
            wr_reg(`TPO_ADDR_FLAGS, rows[i].flag);
            rd_reg(`TPO_ADDR_FLAGS, rd);
            chk8("flag cleared", 8'h00, rd);
        end
        chk10("period reset", 10'h0FF, period_o);
        chk10("duty c reset", 10'h07F, duty_c_o);
        chk6("pins reset", 6'h00, pwm_oe_o);
        chk1("pll reset", 1'b0, pll_power_on_o);
        for (int i = 0; i < 10; i++) begin
            rd_reg(ADDRS[i], rd);
            chk8("reset value", RSTV[i], rd);
        end
        for (int i = 0; i < 10; i++) begin
            wr_reg(ADDRS[i], 8'hFF);
            rd_reg(ADDRS[i], rd);
            chk8("readback", BACKV[i], rd);
        end
        wr_reg(`TPO_ADDR_PERIOD_LOW, 8'h34);
        @(posedge clk_i);
        #1 chk10("period", 10'h334, period_o);
        chk10("duty c", 10'h3FF, duty_c_o);
        for (int i = 0; i < 8; i++) wr_reg(ADDRS[i], 8'h00);
        // Restore the period's high bits so the period stays at 334
        wr_reg(`TPO_ADDR_HIGH, 8'h03);
        wr_reg(`TPO_ADDR_FLAGS, 8'hFC);
        // Interrupt follows flag and mask; it rises only when both are set
        wr_reg(`TPO_ADDR_MASKS, 8'h80);
        hit(10'h334);
        repeat (2) @(posedge clk_i);
        #1 chk1("irq raised", 1'b1, irq_o);
        wr_reg(`TPO_ADDR_FLAGS, 8'h80);
        @(posedge clk_i);
        #1 chk1("irq cleared", 1'b0, irq_o);
        wr_reg(`TPO_ADDR_MASKS, 8'h40);
        hit(10'h334);
        repeat (3) @(posedge clk_i);
        #1 chk1("irq masked", 1'b0, irq_o);
        // Plain timer: compare match lands on overflow and match A
        pwm_enable_bit_i <= 1'b0;
        wr_reg(`TPO_ADDR_MASKS, 8'h20);
        wr_reg(`TPO_ADDR_FLAGS, 8'hFC);
        timer_match_i <= 1'b1;
        @(posedge clk_i);
        timer_match_i <= 1'b0;
        rd_reg(`TPO_ADDR_FLAGS, rd);
        chk8("timer flags", 8'hA0, rd);
        chk1("timer irq", 1'b1, irq_o);
        pwm_enable_bit_i <= 1'b1;
        wr_reg(`TPO_ADDR_MASKS, 8'h00);
        // Capture arriving with its own clear must not be lost
        @(posedge clk_i);
        reg_addr_i <= `TPO_ADDR_FLAGS;
        reg_wdata_i <= 8'hFC;
        reg_we_i <= 1'b1;
        capture_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        capture_i <= 1'b0;
        rd_reg(`TPO_ADDR_FLAGS, rd);
        chk8("set wins", 8'h04, rd);
        wr_reg(`TPO_ADDR_CTRL3, 8'h05);
        @(posedge clk_i);
        #1 chk1("pll on", 1'b1, pll_power_on_o);
        chk1("high freq", 1'b1, high_freq_clock_enable_o);
        repeat (10) @(posedge clk_i);
        #1 chk1("pll settling", 1'b0, pll_stable_o);
        repeat (15) @(posedge clk_i);
        #1 chk1("pll stable", 1'b1, pll_stable_o);
        // Waveform: A positive, B and C negative, no delay
        btb_mode_i <= 1'b0;
        wr_reg(`TPO_ADDR_CTRL3, 8'hC8);
        hit(10'h334);
        repeat (5) @(posedge clk_i);
        #1 chk6("period level", 6'h1A, pin);
        chk6("enables", 6'h3F, pwm_oe_o);
        rise(10'h040, 5, n);
        chk1("undelayed rise", 1'b1, n == 2);
        chk6("duty level", 6'h2A, pin);
        wr_reg(`TPO_ADDR_DLY_A, 8'h55);
        rise(10'h334, 4, n);
        chk1("comp delay", 1'b1, n >= 7 && n <= 9);
        rise(10'h040, 5, n);
        chk1("true delay", 1'b1, n >= 7 && n <= 9);
        wr_reg(`TPO_ADDR_FORCE, 8'h3F);
        repeat (3) @(posedge clk_i);
        #1 chk6("six ignored", 6'h2A, pin);
        wr_reg(`TPO_ADDR_FORCE, 8'h60);
        repeat (3) @(posedge clk_i);
        #1 chk6("six enables", 6'h20, pin);
        wr_reg(`TPO_ADDR_FORCE, 8'h80);
        hit(10'h334);
        repeat (14) @(posedge clk_i);
        #1 chk6("force a", 6'h15, pin);
        wr_reg(`TPO_ADDR_CTRL3, 8'h80);
        repeat (4) @(posedge clk_i);
        #1 chk6("control off", 6'h00, pin);
        wr_reg(`TPO_ADDR_CTRL3, 8'h48);
        repeat (4) @(posedge clk_i);
        #1 chk6("port off", 6'h00, pwm_oe_o);
        chk8("overlap", 8'h00, overlap);
        final_report();
    end
endmodule
`default_nettype wire
